/* File: src/smsf_regs.svh */
/*
 * Register offsets, field positions, reset values and timing constants
 * for the signal monitor status and framer block.
 * Assumes inclusion by bare name from the design modules, the checker and the bench.
 */
`ifndef SMSF_REGS_SVH
`define SMSF_REGS_SVH

`define SMSF_IDX_CTRL 12'h274
`define SMSF_IDX_RES_LO 12'h275
`define SMSF_IDX_RES_MID 12'h276
`define SMSF_IDX_RES_HI 12'h277
`define SMSF_IDX_FRAME_CNT 12'h278
`define SMSF_IDX_FRM_EN 12'h279
`define SMSF_IDX_FRM_SEL 12'h27a
`define SMSF_IDX_IRQ_STAT 12'h280
`define SMSF_IDX_IRQ_MASK 12'h281

`define SMSF_CTRL_UPD_BIT 4
`define SMSF_CTRL_SEL_LSB 0
`define SMSF_RST_RES_SEL 3'h1
`define SMSF_SEL_PEAK 3'h1
`define SMSF_RST_FRM_EN 2'h0
`define SMSF_FRM_EN_ON 2'h3
`define SMSF_RST_FRM_SEL 8'h02
`define SMSF_FRM_SEL_PEAK_BIT 1
`define SMSF_IRQ_UPD_BIT 0
`define SMSF_IRQ_EXP_BIT 1
`define SMSF_IRQ_WRAP_BIT 2
`define SMSF_RST_PERIOD 24'h000080

`endif

/* File: src/smsf_pkg.sv */
/*
 * Types shared by the signal monitor status and framer block.
 * Assumes the register header sits on the include path.
 */
package smsf_pkg;
	typedef enum logic [1:0] {
		SMSF_ST_IDLE,
		SMSF_ST_DATA
	} smsf_frm_state_e;
	typedef logic [19:0] smsf_result_t;
endpackage : smsf_pkg

/* File: src/smsf_framer.sv */
/*
 * Sideband statistics framer: serialises the selected statistics into
 * a word stream for insertion into the outgoing link frames.
 * Assumes the link side accepts one word whenever ready is high.
 */
`include "smsf_regs.svh"
module smsf_framer
	import smsf_pkg::*;
#(
	parameter int RES_W = 20
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Control
	input wire logic [1:0] frm_en_i,
	input wire logic [7:0] frm_sel_i,
	input wire logic period_expire_i,
	input wire logic [RES_W-1:0] peak_result_i,
	// Link side
	output logic [RES_W-1:0] sideband_stats_port_data_o,
	output logic sideband_stats_port_valid_o,
	input wire logic sideband_stats_port_ready_i
);
	// Refuse widths that the word lane cannot carry
	if (RES_W < 1 || RES_W > 32) begin : g_bad_width
		$error("smsf_framer: RES_W out of range");
	end

	smsf_frm_state_e state;
	smsf_frm_state_e next_state;
	wire export_on;
	wire peak_on;
	wire start;
	wire done;

	// Export only when the enable field reads 11
	assign export_on = (frm_en_i == `SMSF_FRM_EN_ON); // [R05]
	assign peak_on = frm_sel_i[`SMSF_FRM_SEL_PEAK_BIT]; // [R06]
	assign start = export_on && peak_on && period_expire_i;
	assign done = sideband_stats_port_ready_i;
	assign sideband_stats_port_valid_o = (state == SMSF_ST_DATA);

	always_comb begin
		next_state = state;
		unique case (state)
			SMSF_ST_IDLE: begin
				if (start) begin
					next_state = SMSF_ST_DATA;
				end
			end
			SMSF_ST_DATA: begin
				if (done) begin
					next_state = SMSF_ST_IDLE;
				end
			end
			default: begin
				next_state = SMSF_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state <= SMSF_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Peak data captured into the frame word at period end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sideband_stats_port_data_o <= '0;
		end else if (state == SMSF_ST_IDLE && start) begin
			sideband_stats_port_data_o <= peak_result_i; // [R08]
		end
	end
endmodule : smsf_framer

/* File: src/smsf_top.sv */
/*
 * Signal monitor status readback and statistics framer control, with
 * an AHB-Lite register slave and a masked interrupt.
 * Registers answer with no wait state; read data is registered.
 * Assumes the period counter expiry and peak result arrive synchronous
 * to sys_clk_i; the host programs only even monitor periods.
 */
// Decided for this implementation: register access over AHB-Lite.
// Functional notes
// R01: Update bit snapshots results, then self-clears
// R02: Result select field resets to one; 001=peak
// R03: 20-bit result over three bytes, nibble reserved
// R04: Frame counter increments on every period expiry
// R05: Framer enable field: 00 off, 11 on
// R06: Input select bit one includes that statistic
// R07: Host programs even monitor period only
// R08: Peak selected means peak data in frame
// R09: All result bytes captured in one cycle
`include "smsf_regs.svh"
module smsf_top
	import smsf_pkg::*;
#(
	parameter int RES_W = 20
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Monitor inputs
	input wire logic period_expire_i,
	input wire logic [RES_W-1:0] peak_result_i,
	// Sideband statistics to link framer
	output logic [RES_W-1:0] sideband_stats_port_data_o,
	output logic sideband_stats_port_valid_o,
	input wire logic sideband_stats_port_ready_i,
	// Interrupt
	output logic irq_o
);
	// Readback layout is fixed at a 20-bit result
	if (RES_W != 20) begin : g_bad_width
		$error("smsf_top: readback layout needs RES_W of 20");
	end

	// Index compare shared by every decoder
	function automatic logic is_idx(input logic [11:0] idx, input logic [11:0] want);
		return idx == want;
	endfunction : is_idx

	// Address phase capture
	logic wr_pend;
	logic [11:0] ph_idx;
	wire take;
	wire take_wr;
	wire take_rd;
	wire [11:0] a_idx;
	assign take = hsel_i && hready_i && htrans_i[1];
	assign take_wr = take && hwrite_i;
	assign take_rd = take && !hwrite_i;
	assign a_idx = haddr_i[13:2];
	// Zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// Write data phase flag
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= take_wr;
		end
	end

	// Index of the register in the data phase
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ph_idx <= 12'h000;
		end else if (take) begin
			ph_idx <= a_idx;
		end
	end

	// Register state
	logic [2:0] res_sel;
	logic upd_req;
	smsf_result_t res_snap;
	logic [7:0] frame_snap;
	logic [7:0] frame_cnt;
	logic [1:0] frm_en;
	logic [7:0] frm_sel;
	wire [2:0] irq_stat;
	logic [2:0] irq_mask;

	// Write strobes, decoded in the data phase
	wire wr_ctrl;
	wire wr_en;
	wire wr_sel;
	wire wr_stat;
	wire wr_mask;
	wire [7:0] wb;
	assign wb = hwdata_i[7:0];
	assign wr_ctrl = wr_pend && is_idx(ph_idx, `SMSF_IDX_CTRL);
	assign wr_en = wr_pend && is_idx(ph_idx, `SMSF_IDX_FRM_EN);
	assign wr_sel = wr_pend && is_idx(ph_idx, `SMSF_IDX_FRM_SEL);
	assign wr_stat = wr_pend && is_idx(ph_idx, `SMSF_IDX_IRQ_STAT);
	assign wr_mask = wr_pend && is_idx(ph_idx, `SMSF_IDX_IRQ_MASK);

	// Read hits, decoded in the address phase
	wire rd_ctrl;
	wire rd_res_lo;
	wire rd_res_mid;
	wire rd_res_hi;
	wire rd_frame;
	wire rd_en;
	wire rd_sel;
	wire rd_stat;
	wire rd_mask;
	assign rd_ctrl = is_idx(a_idx, `SMSF_IDX_CTRL);
	assign rd_res_lo = is_idx(a_idx, `SMSF_IDX_RES_LO);
	assign rd_res_mid = is_idx(a_idx, `SMSF_IDX_RES_MID);
	assign rd_res_hi = is_idx(a_idx, `SMSF_IDX_RES_HI);
	assign rd_frame = is_idx(a_idx, `SMSF_IDX_FRAME_CNT);
	assign rd_en = is_idx(a_idx, `SMSF_IDX_FRM_EN);
	assign rd_sel = is_idx(a_idx, `SMSF_IDX_FRM_SEL);
	assign rd_stat = is_idx(a_idx, `SMSF_IDX_IRQ_STAT);
	assign rd_mask = is_idx(a_idx, `SMSF_IDX_IRQ_MASK);

	// Selected statistic; only the peak detector is wired in
	wire sel_peak;
	wire smsf_result_t sel_result;
	assign sel_peak = (res_sel == `SMSF_SEL_PEAK); // [R02]
	assign sel_result = sel_peak ? peak_result_i : '0; // [R02]

	wire frame_wrap;
	assign frame_wrap = period_expire_i && (frame_cnt == 8'hff);

	// Configuration registers, one block each
	// Result selection in bits 2:0
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			res_sel <= `SMSF_RST_RES_SEL; // [R02]
		end else if (wr_ctrl) begin
			res_sel <= wb[`SMSF_CTRL_SEL_LSB +: 3]; // [R02]
		end
	end

	// Framer enable field
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			frm_en <= `SMSF_RST_FRM_EN; // [R05]
		end else if (wr_en) begin
			frm_en <= wb[1:0]; // [R05]
		end
	end

	// Input selection; bits 7:6 reserved
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			frm_sel <= `SMSF_RST_FRM_SEL; // [R06]
		end else if (wr_sel) begin
			frm_sel <= {2'h0, wb[5:0]}; // [R06]
		end
	end

	// Interrupt mask
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			irq_mask <= 3'h0;
		end else if (wr_mask) begin
			irq_mask <= wb[2:0];
		end
	end

	// Update strobe from a one in the update bit
	wire upd_wr;
	assign upd_wr = wr_ctrl && wb[`SMSF_CTRL_UPD_BIT];

	// Update request lives one cycle, then clears itself
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			upd_req <= 1'b0;
		end else begin
			upd_req <= upd_wr; // [R01]
		end
	end

	// Frame counter, wraps from ff to 00
	wire [7:0] next_frame_cnt;
	assign next_frame_cnt = frame_cnt + 8'h01;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			frame_cnt <= 8'h00;
		end else if (period_expire_i) begin
			frame_cnt <= next_frame_cnt; // [R04]
		end
	end

	// Every result byte snapshots on the same strobe
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			res_snap <= '0;
		end else if (upd_req) begin
			res_snap <= sel_result; // [R01] [R09]
		end
	end

	// Frame count snapshots with the result
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			frame_snap <= 8'h00;
		end else if (upd_req) begin
			frame_snap <= frame_cnt; // [R01] [R09]
		end
	end

	// Sticky events; a new event beats a same-cycle clear
	localparam int IRQ_N = 3;
	wire [IRQ_N-1:0] irq_evt;
	wire [IRQ_N-1:0] irq_clr;
	assign irq_evt[`SMSF_IRQ_UPD_BIT] = upd_req;
	assign irq_evt[`SMSF_IRQ_EXP_BIT] = period_expire_i;
	assign irq_evt[`SMSF_IRQ_WRAP_BIT] = frame_wrap;
	assign irq_clr = wr_stat ? wb[IRQ_N-1:0] : '0;

	// One flag per event
	for (genvar gi = 0; gi < IRQ_N; gi++) begin : g_irq
		logic flag;
		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				flag <= 1'b0;
			end else if (irq_evt[gi]) begin
				flag <= 1'b1;
			end else if (irq_clr[gi]) begin
				flag <= 1'b0;
			end
		end
		assign irq_stat[gi] = flag;
	end

	assign irq_o = |(irq_stat & irq_mask);

	// Readback byte of each register; update bit reads zero
	wire [7:0] ctrl_byte;
	wire [7:0] res_lo_byte;
	wire [7:0] res_mid_byte;
	wire [7:0] res_hi_byte;
	wire [7:0] frame_byte;
	wire [7:0] en_byte;
	wire [7:0] sel_byte;
	wire [7:0] stat_byte;
	wire [7:0] mask_byte;
	assign ctrl_byte = {5'h00, res_sel}; // [R01]
	assign res_lo_byte = res_snap[7:0]; // [R03]
	assign res_mid_byte = res_snap[15:8]; // [R03]
	assign res_hi_byte = {4'h0, res_snap[19:16]}; // [R03]
	assign frame_byte = frame_snap; // [R04]
	assign en_byte = {6'h00, frm_en}; // [R05]
	assign sel_byte = frm_sel; // [R06]
	assign stat_byte = {5'h00, irq_stat};
	assign mask_byte = {5'h00, irq_mask};

	// Read mux on the address phase index
	wire [7:0] rd_byte;
	assign rd_byte =
		rd_ctrl ? ctrl_byte :
		rd_res_lo ? res_lo_byte :
		rd_res_mid ? res_mid_byte :
		rd_res_hi ? res_hi_byte :
		rd_frame ? frame_byte :
		rd_en ? en_byte :
		rd_sel ? sel_byte :
		rd_stat ? stat_byte :
		rd_mask ? mask_byte : 8'h00;

	// Read data registered into the data phase; zero otherwise
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			hrdata_o <= 32'h00000000;
		end else if (take_rd) begin
			hrdata_o <= {24'h000000, rd_byte};
		end else begin
			hrdata_o <= 32'h00000000;
		end
	end

	smsf_framer #(
		.RES_W(RES_W)
	) u_framer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.frm_en_i(frm_en),
		.frm_sel_i(frm_sel),
		.period_expire_i(period_expire_i),
		.peak_result_i(peak_result_i),
		.sideband_stats_port_data_o(sideband_stats_port_data_o),
		.sideband_stats_port_valid_o(sideband_stats_port_valid_o),
		.sideband_stats_port_ready_i(sideband_stats_port_ready_i)
	);
endmodule : smsf_top

/* File: verif/smsf_assertions.sv */
/* Checker on smsf_top ports: bus answers and sideband handshake.
   Assumes the bench binds it to smsf_top. */
`include "smsf_regs.svh"
module smsf_checker #(
	parameter int RES_W = 20
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// Monitor and link
	input wire logic period_expire_i,
	input wire logic [RES_W-1:0] peak_result_i,
	input wire logic [RES_W-1:0] sideband_stats_port_data_o,
	input wire logic sideband_stats_port_valid_o,
	input wire logic sideband_stats_port_ready_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic dph;
	logic [11:0] adq;
	wire v = sideband_stats_port_valid_o;
	wire r = sideband_stats_port_ready_i;
	wire [RES_W-1:0] d = sideband_stats_port_data_o;
	always_ff @(posedge sys_clk_i) begin
		dph <= !rst_i && hsel_i && hready_i && htrans_i[1];
		adq <= haddr_i[13:2];
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_offer; v && !r; endsequence
	sequence s_take; v && r; endsequence
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus answer not ready and okay");
	a_idle_rdata: assert property (!dph |-> hrdata_o == 32'h0)
		else $error("read data outside data phase");
	a_upper_zero: assert property (dph |-> hrdata_o[31:8] == 24'h0)
		else $error("read data above low byte");
	a_hi_nibble: assert property (dph && adq == `SMSF_IDX_RES_HI |-> hrdata_o[7:4] == 4'h0)
		else $error("reserved nibble not zero");
	a_offer_hold: assert property (s_offer |=> v && $stable(d))
		else $error("word changed before accept");
	a_take_drop: assert property (s_take |=> !v)
		else $error("valid stayed after accept");
	a_start_cause: assert property ($rose(v) |-> $past(period_expire_i))
		else $error("word without expiry");
	a_start_data: assert property ($rose(v) |-> d == $past(peak_result_i))
		else $error("word not peak result");
endmodule : smsf_checker

/* File: verif/smsf_sink.sv */
/* Link-side sink model for the sideband statistics port.
   Assumes valid and data are driven by the framer on sys_clk_i. */
module smsf_sink (
	// Clock, reset and pace
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	// Stream
	input wire logic valid_i,
	input wire logic [19:0] data_i,
	output logic ready_o,
	output int got_o,
	output logic [19:0] last_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph = 2'h0;
	// Slow pace accepts one cycle in four
	assign ready_o = !slow_i || ph == 2'h3;
	always @(posedge sys_clk_i) begin
		ph <= ph + 2'h1;
		if (rst_i) begin
			got_o <= 0;
		end else if (valid_i && ready_o) begin
			got_o <= got_o + 1;
			last_o <= data_i;
		end
	end
endmodule : smsf_sink

/* File: verif/smsf_top_tb.sv */
/* Self-checking bench for smsf_top: registers, snapshot, framer, irq.
   Assumes the checker and sink model are compiled first. */
`include "smsf_regs.svh"
module smsf_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, expi = 0, slow = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
	logic hready, hresp, irq, valid, ready;
	logic [19:0] peak = 20'h0, sdata, last;
	int got, err_count = 0, num_checks = 0;
	logic [43:0] rows [10] = '{{12'h274, 32'h1}, {12'h275, 32'h0}, {12'h276, 32'h0},
		{12'h277, 32'h0}, {12'h278, 32'h0}, {12'h279, 32'h0}, {12'h27a, 32'h2},
		{12'h280, 32'h0}, {12'h281, 32'h0}, {12'h2ff, 32'h0}};
	always #10 clk = !clk;
	smsf_top #(.RES_W(20)) uut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .period_expire_i(expi), .peak_result_i(peak),
		.sideband_stats_port_data_o(sdata), .sideband_stats_port_valid_o(valid),
		.sideband_stats_port_ready_i(ready), .irq_o(irq));
	smsf_sink mdl (.sys_clk_i(clk), .rst_i(rst), .slow_i(slow), .valid_i(valid), .data_i(sdata),
		.ready_o(ready), .got_o(got), .last_o(last));
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic bus(logic w, logic [11:0] ix, logic [31:0] dat);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {18'h0, ix, 2'h0};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= dat;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic rc(logic [11:0] ix, logic [31:0] e);
		bus(1'b0, ix, 32'h0);
		chk("register", e, rd);
	endtask : rc
	task automatic pulse();
		@(posedge clk);
		expi <= 1'b1;
		@(posedge clk);
		expi <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : pulse
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	initial begin
		#100us;
		err_count++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) rc(rows[i][43:32], rows[i][31:0]);
		bus(1'b1, `SMSF_IDX_RES_LO, 32'hff);
		rc(`SMSF_IDX_RES_LO, 32'h0);
		peak <= 20'h5a5a5;
		bus(1'b1, `SMSF_IDX_FRM_EN, 32'h1);
		pulse();
		chk("words", 32'h0, got);
		bus(1'b1, `SMSF_IDX_FRM_EN, 32'h3);
		bus(1'b1, `SMSF_IDX_FRM_SEL, 32'h0);
		pulse();
		chk("words", 32'h0, got);
		bus(1'b1, `SMSF_IDX_FRM_SEL, 32'h2);
		slow <= 1'b1;
		pulse();
		chk("words", 32'h1, got);
		chk("word", 32'h5a5a5, {12'h0, last});
		bus(1'b1, `SMSF_IDX_CTRL, 32'h11);
		rc(`SMSF_IDX_RES_LO, 32'ha5);
		rc(`SMSF_IDX_RES_MID, 32'ha5);
		rc(`SMSF_IDX_RES_HI, 32'h5);
		rc(`SMSF_IDX_FRAME_CNT, 32'h3);
		rc(`SMSF_IDX_CTRL, 32'h1);
		rc(`SMSF_IDX_IRQ_STAT, 32'h3);
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, `SMSF_IDX_IRQ_MASK, 32'h2);
		#1 chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, `SMSF_IDX_IRQ_STAT, 32'h2);
		#1 chk("irq", 32'h0, {31'h0, irq});
		rc(`SMSF_IDX_IRQ_STAT, 32'h1);
		bus(1'b1, `SMSF_IDX_CTRL, 32'h12);
		rc(`SMSF_IDX_RES_LO, 32'h0);
		bus(1'b1, `SMSF_IDX_FRM_EN, 32'h0);
		repeat (253) pulse();
		rc(`SMSF_IDX_IRQ_STAT, 32'h7);
		bus(1'b1, `SMSF_IDX_CTRL, 32'h13);
		rc(`SMSF_IDX_FRAME_CNT, 32'h0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rc(`SMSF_IDX_CTRL, 32'h1);
		rc(`SMSF_IDX_FRAME_CNT, 32'h0);
		print_verdict();
	end
endmodule : smsf_top_tb
bind smsf_top smsf_checker #(.RES_W(RES_W)) chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.period_expire_i(period_expire_i), .peak_result_i(peak_result_i),
	.sideband_stats_port_data_o(sideband_stats_port_data_o),
	.sideband_stats_port_valid_o(sideband_stats_port_valid_o),
	.sideband_stats_port_ready_i(sideband_stats_port_ready_i));
